// >>> hw/sps_pkg.sv
// Purpose: shared constants and types for the standby pin-state controller
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: one lane per port pin; lanes below INT_LANES carry ext interrupts
`default_nettype none
package sps_pkg;
	localparam int NPINS = 8;
	localparam int INT_LANES = 4;
	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_STBY = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_DIR = 8'h08;
	localparam logic [7:0] OFF_FSEL = 8'h0C;
	localparam logic [7:0] OFF_PULL = 8'h10;
	localparam logic [7:0] OFF_IREN = 8'h14;
	localparam logic [7:0] OFF_ANEN = 8'h18;
	localparam logic [7:0] OFF_PIN = 8'h1C;
	localparam logic [7:0] OFF_STAT = 8'h20;
	// ---------------------------------------------------------------
	// standby register fields and reset values
	// ---------------------------------------------------------------
	localparam int STBY_SEL_BIT = 0;
	localparam int STBY_MODE_LSB = 4;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		SPS_RUN = 2'b00,
		SPS_SLEEP = 2'b01,
		SPS_STOP = 2'b10,
		SPS_WATCH = 2'b11
	} sps_mode_t;

	// pad-facing bundle for one pin
	typedef struct packed {
		logic out;
		logic oe;
		logic pull_en;
		logic ie;
	} sps_pad_t;
endpackage
`default_nettype wire

// >>> hw/sps_lane.sv
// Purpose: pin-state logic of one port lane
// Assumes: mode and select are registered in the parent
// Notes: combinational; parent registers the pad outputs
`default_nettype none
module sps_lane #(
	parameter bit HAS_INT = 1'b0,
	parameter bit HAS_ANA = 1'b0
) (
	input wire sps_pkg::sps_mode_t mode, // operating mode
	input wire logic sel, // standby pin-state select
	input wire logic in_reset, // reset window after release
	input wire logic gpio_out, // port data
	input wire logic gpio_dir, // 1 = output
	input wire logic fsel, // 1 = peripheral owns pin
	input wire logic periph_out, // peripheral output
	input wire logic periph_oe, // peripheral drive enable
	input wire logic pull, // pull-up setting
	input wire logic irq_en, // ext interrupt request enable
	input wire logic ana_en, // analog input select
	input wire logic held_out, // last driven value
	input wire logic held_oe, // last drive enable
	input wire logic pad_in, // pad level
	output sps_pkg::sps_pad_t pad, // next pad controls
	output logic gate_in, // gated input to logic
	output logic irq_in // gated input to interrupt
);
	import sps_pkg::*;
	logic standby;
	logic ie;
	// ---------------------------------------------------------------
	// per-mode pad control
	// ---------------------------------------------------------------
	always_comb begin
		standby = (mode == SPS_STOP) || (mode == SPS_WATCH);
		pad = '0;
		ie = 1'b0;
		if (in_reset) begin
			// analog pins blocked, digital pins enabled but unused
			ie = !HAS_ANA;
		end else if (standby && !sel) begin
			pad.out = held_out;
			pad.oe = held_oe;
		end else if (standby) begin
			pad.pull_en = pull;
		end else begin
			// run and sleep: port or peripheral
			pad.out = fsel ? periph_out : gpio_out;
			pad.oe = fsel ? periph_oe : gpio_dir;
			pad.pull_en = pull & ~pad.oe;
			// analog use disconnects the digital buffer
			ie = !(HAS_ANA && ana_en);
		end
		pad.ie = ie | (HAS_INT && standby && irq_en);
		gate_in = ie & pad_in;
		// interrupt path survives standby when enabled
		irq_in = HAS_INT && irq_en && pad.ie && pad_in;
	end
endmodule
`default_nettype wire

// >>> hw/sps_top.sv
// Purpose: standby pin-state controller with apb registers
// Assumes: pclk 125 MHz, pad inputs synchronous to pclk
// Notes: pads never float by design; board pulls enabled inputs
// Notes on behaviour
// - with select clear in stop or watch, pins hold their last drive and inputs are blocked.
// - with select set in stop or watch, pins go high impedance, inputs blocked, pull-up kept.
// - blocked inputs cut the gate path on every lane; enabled ext interrupt lanes still pass to the irq output.
// - in stop or watch, an ext interrupt-enabled pin below INT_LANES keeps its input buffer connected.
// - an output-port pin follows the same state rules as every other port pin.
// - in reset, digital pins are hi-z with input enabled, analog pins hi-z and blocked.
`default_nettype none
module sps_top (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [sps_pkg::NPINS-1:0] periph_out, // peripheral outputs
	input wire logic [sps_pkg::NPINS-1:0] periph_oe, // peripheral enables
	input wire logic [sps_pkg::NPINS-1:0] pad_in, // pad levels
	output sps_pkg::sps_pad_t [sps_pkg::NPINS-1:0] pad, // pad controls
	output logic [sps_pkg::NPINS-1:0] gate_in, // gated inputs
	output logic [sps_pkg::NPINS-1:0] ext_interrupt_input, // irq inputs
	output logic [sps_pkg::NPINS-1:0] analog_input_en // analog switch
);
	import sps_pkg::*;

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic standby_pin_state_select, next_sel;
	sps_mode_t mode, next_mode;
	logic [NPINS-1:0] data, next_data;
	logic [NPINS-1:0] dir, next_dir;
	logic [NPINS-1:0] fsel, next_fsel;
	logic [NPINS-1:0] pull, next_pull;
	logic [NPINS-1:0] iren, next_iren;
	logic [NPINS-1:0] anen, next_anen;
	logic [NPINS-1:0] held_out, next_held_out;
	logic [NPINS-1:0] held_oe, next_held_oe;
	logic in_reset;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	sps_pad_t [NPINS-1:0] next_pad;
	logic [NPINS-1:0] next_gate, next_irq, next_anout;
	logic wr, rd, setup;

	// ---------------------------------------------------------------
	// apb decode and register writes
	// ---------------------------------------------------------------
	// no wait state: answer in the cycle after the setup phase
	always_comb begin
		setup = psel && !penable;
		wr = psel && penable && pready && pwrite;
		rd = setup && !pwrite;
		next_sel = standby_pin_state_select;
		next_mode = mode;
		next_data = data;
		next_dir = dir;
		next_fsel = fsel;
		next_pull = pull;
		next_iren = iren;
		next_anen = anen;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		next_pready = setup;
		if (wr) begin
			if (paddr == OFF_STBY) begin
				next_sel = pwdata[STBY_SEL_BIT];
				next_mode = sps_mode_t'(pwdata[STBY_MODE_LSB +: 2]);
			end else if (paddr == OFF_DATA) begin
				next_data = pwdata[NPINS-1:0];
			end else if (paddr == OFF_DIR) begin
				next_dir = pwdata[NPINS-1:0];
			end else if (paddr == OFF_FSEL) begin
				next_fsel = pwdata[NPINS-1:0];
			end else if (paddr == OFF_PULL) begin
				next_pull = pwdata[NPINS-1:0];
			end else if (paddr == OFF_IREN) begin
				next_iren = pwdata[NPINS-1:0];
			end else if (paddr == OFF_ANEN) begin
				next_anen = pwdata[NPINS-1:0];
			end
		end
		// error flagged in the access phase for unmapped or unaligned words and for writes to PIN or STAT
		if (setup) begin
			next_pslverr = (paddr > OFF_STAT) || (paddr[1:0] != 2'b00)
				|| (pwrite && (paddr == OFF_PIN || paddr == OFF_STAT));
		end
		if (rd) begin
			next_prdata = RST_WORD;
			if (paddr == OFF_STBY) begin
				next_prdata[STBY_SEL_BIT] = standby_pin_state_select;
				next_prdata[STBY_MODE_LSB +: 2] = mode;
			end else if (paddr == OFF_DATA) begin
				next_prdata[NPINS-1:0] = data;
			end else if (paddr == OFF_DIR) begin
				next_prdata[NPINS-1:0] = dir;
			end else if (paddr == OFF_FSEL) begin
				next_prdata[NPINS-1:0] = fsel;
			end else if (paddr == OFF_PULL) begin
				next_prdata[NPINS-1:0] = pull;
			end else if (paddr == OFF_IREN) begin
				next_prdata[NPINS-1:0] = iren;
			end else if (paddr == OFF_ANEN) begin
				next_prdata[NPINS-1:0] = anen;
			end else if (paddr == OFF_PIN) begin
				next_prdata[NPINS-1:0] = gate_in;
			end else if (paddr == OFF_STAT) begin
				// live pad drive enables show the block's own state
				for (int i = 0; i < NPINS; i++) begin
					next_prdata[i] = pad[i].oe;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// capture of the state held through standby
	// ---------------------------------------------------------------
	// sampled from the pads while not in standby, frozen inside it
	always_comb begin
		next_held_out = held_out;
		next_held_oe = held_oe;
		if (mode == SPS_RUN || mode == SPS_SLEEP) begin
			for (int i = 0; i < NPINS; i++) begin
				next_held_out[i] = pad[i].out;
				next_held_oe[i] = pad[i].oe;
			end
		end
	end

	// ---------------------------------------------------------------
	// per-lane pin-state logic
	// ---------------------------------------------------------------
	for (genvar g = 0; g < NPINS; g++) begin : g_lane
		sps_lane #(
			.HAS_INT(g < INT_LANES),
			.HAS_ANA(g < INT_LANES)
		) u_lane (
			.mode(mode),
			.sel(standby_pin_state_select),
			.in_reset(in_reset),
			.gpio_out(data[g]),
			.gpio_dir(dir[g]),
			.fsel(fsel[g]),
			.periph_out(periph_out[g]),
			.periph_oe(periph_oe[g]),
			.pull(pull[g]),
			.irq_en(iren[g]),
			.ana_en(anen[g]),
			.held_out(held_out[g]),
			.held_oe(held_oe[g]),
			.pad_in(pad_in[g]),
			.pad(next_pad[g]),
			.gate_in(next_gate[g]),
			.irq_in(next_irq[g])
		);
		// analog switch only outside reset and standby
		assign next_anout[g] = (g < INT_LANES) && anen[g] && !in_reset
			&& (mode == SPS_RUN || mode == SPS_SLEEP);
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// in_reset keeps the reset pin state for one edge after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_pin_state_select <= 1'b0;
			mode <= SPS_RUN;
			data <= RST_BYTE;
			dir <= RST_BYTE;
			fsel <= RST_BYTE;
			pull <= RST_BYTE;
			iren <= RST_BYTE;
			anen <= RST_BYTE;
			held_out <= RST_BYTE;
			held_oe <= RST_BYTE;
			in_reset <= 1'b1;
			prdata <= RST_WORD;
			pready <= 1'b0;
			pslverr <= 1'b0;
			// digital lanes input enabled, analog lanes blocked
			for (int i = 0; i < NPINS; i++) begin
				pad[i] <= '{out: 1'b0, oe: 1'b0, pull_en: 1'b0,
					ie: (i >= INT_LANES)};
			end
			gate_in <= RST_BYTE;
			ext_interrupt_input <= RST_BYTE;
			analog_input_en <= RST_BYTE;
		end else begin
			standby_pin_state_select <= next_sel;
			mode <= next_mode;
			data <= next_data;
			dir <= next_dir;
			fsel <= next_fsel;
			pull <= next_pull;
			iren <= next_iren;
			anen <= next_anen;
			held_out <= next_held_out;
			held_oe <= next_held_oe;
			in_reset <= 1'b0;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			pad <= next_pad;
			gate_in <= next_gate;
			ext_interrupt_input <= next_irq;
			analog_input_en <= next_anout;
		end
	end
endmodule
`default_nettype wire

// >>> dv/sps_monitor.sv
// Purpose: port-level checks on the standby pin-state controller
// Assumes: register writes are mirrored from the apb port
// Notes: checks wait three quiet cycles after a register write
`default_nettype none
module sps_monitor (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic [sps_pkg::NPINS-1:0] periph_out, // peripheral out
	input wire logic [sps_pkg::NPINS-1:0] periph_oe, // peripheral oe
	input wire logic [sps_pkg::NPINS-1:0] pad_in, // pad levels
	input wire sps_pkg::sps_pad_t [sps_pkg::NPINS-1:0] pad, // pads
	input wire logic [sps_pkg::NPINS-1:0] gate_in, // gated inputs
	input wire logic [sps_pkg::NPINS-1:0] ext_interrupt_input, // irq
	input wire logic [sps_pkg::NPINS-1:0] analog_input_en // analog
);
	timeunit 1ns;
	timeprecision 1ps;
	import sps_pkg::*;
	// ----
	// register mirror
	// ----
	logic [7:0] rg [0:6];
	logic [7:0] next_rg [0:6];
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic [7:0] oe_v, out_v, pull_v, ie_v;
	wire wr_ok = psel && penable && pready && pwrite && paddr < OFF_PIN;
	wire stby = rg[0][5];
	wire sel = rg[0][0];
	// refused writes never reach the mirror
	always_comb begin
		next_rg = rg;
		next_cnt = (cnt == 2'h3) ? cnt : cnt + 2'h1;
		if (wr_ok && paddr[1:0] == 2'h0) begin
			next_rg[paddr[4:2]] = pwdata[7:0];
			next_cnt = 2'h0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rg <= '{default: 8'h00};
			cnt <= 2'h0;
		end else begin
			rg <= next_rg;
			cnt <= next_cnt;
		end
	end
	// pad fields as lane vectors
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			{out_v[i], oe_v[i], pull_v[i], ie_v[i]} = pad[i];
		end
	end
	// ----
	// assertions
	// ----
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	AST_RDY: assert property (s_setup |=> pready && penable)
		else $error("no ready after setup");
	AST_ERR: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_RST: assert property ($rose(presetn) |->
		ie_v == 8'hF0 && oe_v == 8'h00)
		else $error("reset pad state wrong");
	AST_HOLD: assert property (cnt == 2'h3 && stby && !sel |->
		$stable(oe_v) && $stable(out_v))
		else $error("held pin state moved");
	AST_HIZ: assert property (cnt == 2'h3 && stby && sel |->
		oe_v == 8'h00 && pull_v == rg[4])
		else $error("standby hi-z or pull wrong");
	AST_BLOCK: assert property (cnt == 2'h3 && stby |->
		gate_in == 8'h00 && ie_v == (rg[5] & 8'h0F))
		else $error("input not blocked");
	AST_IRQ: assert property (cnt == 2'h3 && stby
		&& $stable(pad_in) |->
		ext_interrupt_input == (pad_in & rg[5] & 8'h0F))
		else $error("irq pass wrong");
	AST_ANA: assert property (cnt == 2'h3 |->
		analog_input_en == (stby ? 8'h00 : rg[6] & 8'h0F))
		else $error("analog enable wrong");
	AST_OUT: assert property (cnt == 2'h3 && !stby
		&& rg[3] == 8'h00 |->
		oe_v == rg[2] && (out_v & rg[2]) == (rg[1] & rg[2]))
		else $error("port drive wrong");
endmodule
bind sps_top sps_monitor sps_monitor_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.periph_out(periph_out), .periph_oe(periph_oe), .pad_in(pad_in),
	.pad(pad), .gate_in(gate_in), .ext_interrupt_input(ext_interrupt_input),
	.analog_input_en(analog_input_en));
`default_nettype wire

// >>> dv/sps_board.sv
// Purpose: board circuitry on the port pins
// Assumes: device drive wins over the board
// Notes: undriven lanes are pulled down unless pulled up on chip
`default_nettype none
module sps_board (
	input wire sps_pkg::sps_pad_t [sps_pkg::NPINS-1:0] pad, // pad controls
	input wire logic [sps_pkg::NPINS-1:0] ext_en, // board drives lane
	input wire logic [sps_pkg::NPINS-1:0] ext_lvl, // board level
	output logic [sps_pkg::NPINS-1:0] pad_in // resolved level
);
	timeunit 1ns;
	timeprecision 1ps;
	import sps_pkg::*;
	// a floating lane never reaches the device
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			if (pad[i].oe) begin
				pad_in[i] = pad[i].out;
			end else if (ext_en[i]) begin
				pad_in[i] = ext_lvl[i];
			end else begin
				pad_in[i] = pad[i].pull_en;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/sps_top_tb.sv
// Purpose: directed bench for the standby pin-state controller
// Assumes: apb answers in the access cycle
// Notes: lane 1 is an input driven by the board
`default_nettype none
module sps_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sps_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, po, poe, pin, gate_in, irq, ana, ext_en, ext_lvl;
	logic [31:0] pwdata, prdata;
	sps_pad_t [NPINS-1:0] pad;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	sps_top sps_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_out(po), .periph_oe(poe), .pad_in(pin), .pad(pad),
		.gate_in(gate_in), .ext_interrupt_input(irq), .analog_input_en(ana));
	sps_board sps_board_i (.pad(pad), .ext_en(ext_en), .ext_lvl(ext_lvl),
		.pad_in(pin));
	// ----
	// tasks
	// ----
	task automatic wrap_up();
		$display("mismatches %0d compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// pin-side results are one byte, one bit per lane
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t pin got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until ready is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] xr, input logic xe);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w) chk(prdata, xr);
		chk({31'h0, pslverr}, {31'h0, xe});
		{psel, penable} <= 2'b00;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	function automatic logic [7:0] fld(input int k);
		logic [7:0] v;
		for (int i = 0; i < NPINS; i++) v[i] = pad[i][k];
		return v;
	endfunction
	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			bad_count++;
			wrap_up();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{po, poe, ext_en, ext_lvl} = {8'h00, 8'h00, 8'h02, 8'hFF};
		idle(2);
		chk_pin(fld(0), 8'hF0);
		chk_pin(fld(2), 8'h00);
		presetn <= 1'b1;
		bus(1'b1, OFF_DIR, 32'h0000_00FD, 32'h0, 1'b0);
		bus(1'b1, OFF_DATA, 32'h0000_00A5, 32'h0, 1'b0);
		bus(1'b1, OFF_PULL, 32'h0000_000F, 32'h0, 1'b0);
		bus(1'b1, OFF_IREN, 32'h0000_0002, 32'h0, 1'b0);
		bus(1'b1, OFF_ANEN, 32'h0000_0001, 32'h0, 1'b0);
		bus(1'b1, OFF_PIN, 32'h0000_00FF, 32'h0, 1'b1);
		bus(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
		idle(3);
		bus(1'b0, OFF_STAT, 32'h0, 32'h0000_00FD, 1'b0);
		chk_pin(gate_in & 8'h02, 8'h02);
		chk_pin(ana, 8'h01);
		bus(1'b1, OFF_STBY, 32'h0000_0020, 32'h0, 1'b0);
		idle(3);
		// data lands in the register but not on the held pins
		bus(1'b1, OFF_DATA, 32'h0000_005A, 32'h0, 1'b0);
		bus(1'b0, OFF_DATA, 32'h0, 32'h0000_005A, 1'b0);
		idle(3);
		chk_pin(fld(2), 8'hFD);
		chk_pin(fld(3) & 8'hFD, 8'hA5);
		chk_pin(gate_in, 8'h00);
		chk_pin(irq, 8'h02);
		ext_lvl <= 8'h00;
		idle(3);
		chk_pin(irq, 8'h00);
		ext_lvl <= 8'hFF;
		bus(1'b1, OFF_STBY, 32'h0000_0031, 32'h0, 1'b0);
		bus(1'b0, OFF_STBY, 32'h0, 32'h0000_0031, 1'b0);
		idle(3);
		chk_pin(fld(2), 8'h00);
		chk_pin(fld(1), 8'h0F);
		chk_pin(irq, 8'h02);
		chk_pin(ana, 8'h00);
		bus(1'b1, OFF_STBY, 32'h0, 32'h0, 1'b0);
		idle(3);
		chk_pin(fld(3) & 8'hFD, 8'h58);
		chk_pin(gate_in & 8'h02, 8'h02);
		// analog use of lane 1 cuts its digital input
		bus(1'b1, OFF_ANEN, 32'h0000_0002, 32'h0, 1'b0);
		idle(3);
		bus(1'b0, OFF_PIN, 32'h0, 32'h0000_0058, 1'b0);
		chk_pin(ana, 8'h02);
		chk_pin(fld(0) & 8'h02, 8'h00);
		// peripheral owns every pin, then sleep keeps it
		po <= 8'h3C;
		poe <= 8'hF0;
		bus(1'b1, OFF_FSEL, 32'h0000_00FF, 32'h0, 1'b0);
		idle(3);
		chk_pin(fld(2), 8'hF0);
		chk_pin(fld(3) & 8'hF0, 8'h30);
		bus(1'b1, OFF_STBY, 32'h0000_0010, 32'h0, 1'b0);
		idle(3);
		chk_pin(fld(2), 8'hF0);
		chk_pin(ana, 8'h02);
		// stop from sleep holds the peripheral drive
		bus(1'b1, OFF_STBY, 32'h0000_0020, 32'h0, 1'b0);
		poe <= 8'h0F;
		idle(3);
		chk_pin(fld(2), 8'hF0);
		chk_pin(fld(3), 8'h3C);
		// reset while in stop, from standby
		presetn <= 1'b0;
		idle(2);
		chk_pin(fld(0), 8'hF0);
		chk_pin(fld(2), 8'h00);
		presetn <= 1'b1;
		bus(1'b0, OFF_FSEL, 32'h0, 32'h0, 1'b0);
		idle(2);
		chk_pin(fld(0), 8'hFF);
		chk_pin(fld(2), 8'h00);
		chk_pin(gate_in, 8'h02);
		wrap_up();
	end
endmodule
`default_nettype wire
